/* pkg/mcr_consts.vh */
// Register offsets, field positions and reset values of the interrupt-message capability block.
`ifndef MCR_CONSTS_VH
`define MCR_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define MCR_OFF_PM_BRIDGE_EXT 8'h56
`define MCR_OFF_PM_DATA_BYTE 8'h57
`define MCR_OFF_CAPABILITY_IDENTIFIER 8'h58
`define MCR_OFF_NEXT_PTR 8'h59
`define MCR_OFF_CONTROL 8'h5a
`define MCR_OFF_ADDRESS 8'h5c
`define MCR_OFF_DATA 8'h60
`define MCR_OFF_SOURCE_SEL 8'h70
`define MCR_OFF_STATUS 8'h74

// ----------------------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------------------
`define MCR_CAPABILITY_IDENTIFIER_VAL 8'h05
`define MCR_NEXT_PTR_VAL 8'h64
`define MCR_MULT_CAPABLE 3'h1
`define MCR_ADDR_RESET 32'hfee00000
`define MCR_ADDR_WINDOW 12'hfee
`define MCR_DATA_RESET 16'h0000
`define MCR_ZERO_BYTE 8'h00

// ----------------------------------------------------------------------------
// Field positions and source count
// ----------------------------------------------------------------------------
`define MCR_CTL_ENABLE 0
`define MCR_CTL_MME_HI 6
`define MCR_CTL_MME_LO 4
`define MCR_ADDR_HI_LO 20
`define MCR_ADDR_DEST_MODE 2
`define MCR_ADDR_HINT 3
`define MCR_DATA_TRIGGER 15
`define MCR_DATA_DSTATUS 14
`define MCR_DATA_DEST_MODE 11
`define MCR_DATA_LOW_HI 10
`define MCR_NUM_SOURCES 5

`endif

/* hdl/mcr_msg_launch.v */
// Launches one upstream message memory write per accepted interrupt request.
`timescale 1ns/1ps

`include "mcr_consts.vh"

module mcr_msg_launch (
    input wire sys_clk,
    input wire resetn,
    input wire clk_en,
    input wire fire,
    input wire [31:0] addr_in,
    input wire [15:0] data_in,
    output reg wr_valid_reg,
    output reg [31:0] wr_addr_reg,
    output reg [31:0] wr_data_reg
);

    // ------------------------------------------------------------------------
    // Write launch register
    // ------------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!resetn) begin
            wr_valid_reg <= 1'b0;
            wr_addr_reg <= 32'h00000000;
            wr_data_reg <= 32'h00000000;
        end else if (clk_en) begin
            wr_valid_reg <= fire; // see [R3]
            if (fire) begin
                wr_addr_reg <= {addr_in[31:2], 2'b00}; // see [R20]
                wr_data_reg <= {16'h0000, data_in}; // see [R20]
            end
        end
    end

endmodule // mcr_msg_launch

/* hdl/mcr_cap_regs.v */
// Interrupt-message and power-management extension capability registers.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps

`include "mcr_consts.vh"

// Overview of operation
// [R1] Capability identifier reads fixed code 05h.
// [R2] Next pointer is read-only and returns 64h.
// [R3] Message interrupts are memory writes into the FEEx_xxxxh window.
// [R4] Control bit 0 selects legacy (0) or message (1); resets clear.
// [R5] No source selected means no interrupt of either kind.
// [R6] Software writes power-of-two message count, at least one when enabled.
// [R7] Requested-message field reads 001b, two messages.
// [R8] Wide-address capable bit reads zero; 32-bit addresses only.
// [R9] Address bits 31:20 read-write, reset FEEh.
// [R10] Destination ID bits 19:12 read-write; may be substituted on redirect.
// [R11] Extended destination ID bits 11:4 read-write, reset zero.
// [R12] Address bit 3 is the redirection hint.
// [R13] Address bit 2 is destination mode, meaningful only with hint set.
// [R14] Data bit 15 is trigger mode, edge 0, level 1, reset 0.
// [R15] Data bit 14 reads 1 for edge, interrupt input for level.
// [R16] Data bit 11 is read-write destination mode like address bit 2.
// [R17] Data bits 10:8 delivery mode, 7:0 vector, both reset zero.
// [R18] Power-management data byte always reads zero.
// [R19] Bridge-extension bits 7 and 6 read zero.
// [R20] Message write uses address with low bits zero, data from data register.
module mcr_cap_regs #(
    parameter NUM_SRC = `MCR_NUM_SOURCES
) (
    input wire sys_clk,
    input wire resetn,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata_reg,
    input wire [NUM_SRC-1:0] int_cond,
    input wire [7:0] dest_override,
    input wire dest_override_en,
    output reg legacy_int_reg,
    output wire msg_wr_valid,
    output wire [31:0] msg_wr_addr,
    output wire [31:0] msg_wr_data
);

    // ------------------------------------------------------------------------
    // Software-visible state
    // ------------------------------------------------------------------------
    reg msi_enable_reg;
    reg [2:0] mult_msg_en_reg;
    reg [29:0] addr_hi_reg;
    reg [15:0] data_reg;
    reg [NUM_SRC-1:0] source_sel_reg;
    reg [NUM_SRC-1:0] cond_prev_reg;
    reg [31:0] msg_count_reg;
    reg [31:0] rdata_next;
    reg level_state_reg;

    wire [31:0] address_word;
    wire [15:0] data_word;
    wire [15:0] control_word;
    wire [NUM_SRC-1:0] cond_live;
    wire [NUM_SRC-1:0] cond_rise;
    wire any_live;
    wire any_rise;
    wire level_mode;
    wire fire;
    wire [7:0] dest_id;
    wire [31:0] launch_addr;
    wire [31:0] addr_reset_word;

    assign addr_reset_word = `MCR_ADDR_RESET;

    // ------------------------------------------------------------------------
    // Source gating
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_src
            assign cond_live[gi] = int_cond[gi] & source_sel_reg[gi]; // see [R5]
            assign cond_rise[gi] = cond_live[gi] & ~cond_prev_reg[gi];
        end
    endgenerate

    assign any_live = |cond_live;
    assign any_rise = |cond_rise;
    assign level_mode = data_reg[`MCR_DATA_TRIGGER]; // see [R14]

    // Edge mode sends one assertion in each cycle in which any source rises; level mode also
    // sends when the combined input changes state.
    assign fire = msi_enable_reg & (any_rise | (level_mode & (any_live != level_state_reg)));

    // ------------------------------------------------------------------------
    // Register images
    // ------------------------------------------------------------------------
    assign address_word = {addr_hi_reg, 2'b00};
    // Delivery status follows the mode: fixed 1 for edge, input state for level.
    assign data_word = {data_reg[`MCR_DATA_TRIGGER],
                        level_mode ? level_state_reg : 1'b1, // see [R15]
                        2'b00,
                        data_reg[`MCR_DATA_DEST_MODE:0]}; // see [R16] see [R17]
    assign control_word = {8'h00,
                           1'b0, // see [R8]
                           mult_msg_en_reg,
                           `MCR_MULT_CAPABLE, // see [R7]
                           msi_enable_reg};

    // Destination may be replaced when the message is redirected onto the
    // processor bus; the hint and destination mode then pass through.
    assign dest_id = (dest_override_en && address_word[`MCR_ADDR_HINT]) ?
                     dest_override : address_word[19:12]; // see [R10] see [R12] see [R13]
    assign launch_addr = {address_word[31:20], dest_id, address_word[11:0]};

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!resetn) begin
            msi_enable_reg <= 1'b0; // see [R4]
            mult_msg_en_reg <= 3'h0;
            addr_hi_reg <= addr_reset_word[31:2]; // see [R9] see [R11]
            data_reg <= `MCR_DATA_RESET; // see [R14] see [R17]
            source_sel_reg <= {NUM_SRC{1'b0}};
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `MCR_OFF_CONTROL: begin
                    msi_enable_reg <= reg_wdata[`MCR_CTL_ENABLE]; // see [R4]
                    mult_msg_en_reg <= reg_wdata[`MCR_CTL_MME_HI:`MCR_CTL_MME_LO];
                end
                `MCR_OFF_ADDRESS: begin
                    addr_hi_reg <= reg_wdata[31:2]; // see [R9] see [R10] see [R11]
                end
                `MCR_OFF_DATA: begin
                    data_reg <= {reg_wdata[15:14], 2'b00, reg_wdata[11:0]};
                end
                `MCR_OFF_SOURCE_SEL: begin
                    source_sel_reg <= reg_wdata[NUM_SRC-1:0];
                end
                default: begin
                    msi_enable_reg <= msi_enable_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt state
    // ------------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (!resetn) begin
            cond_prev_reg <= {NUM_SRC{1'b0}};
            level_state_reg <= 1'b0;
            legacy_int_reg <= 1'b0;
            msg_count_reg <= 32'h00000000;
        end else if (clk_en) begin
            cond_prev_reg <= cond_live;
            level_state_reg <= any_live;
            legacy_int_reg <= any_live & ~msi_enable_reg; // see [R4] see [R5]
            if (fire) begin
                msg_count_reg <= msg_count_reg + 32'h00000001;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------------
    always @* begin
        rdata_next = 32'h00000000;
        case (reg_addr)
            `MCR_OFF_PM_BRIDGE_EXT: rdata_next = {24'h000000, `MCR_ZERO_BYTE}; // see [R19]
            `MCR_OFF_PM_DATA_BYTE: rdata_next = {24'h000000, `MCR_ZERO_BYTE}; // see [R18]
            `MCR_OFF_CAPABILITY_IDENTIFIER: rdata_next = {24'h000000, `MCR_CAPABILITY_IDENTIFIER_VAL}; // see [R1]
            `MCR_OFF_NEXT_PTR: rdata_next = {24'h000000, `MCR_NEXT_PTR_VAL}; // see [R2]
            `MCR_OFF_CONTROL: rdata_next = {16'h0000, control_word};
            `MCR_OFF_ADDRESS: rdata_next = address_word;
            `MCR_OFF_DATA: rdata_next = {16'h0000, data_word};
            `MCR_OFF_SOURCE_SEL: rdata_next = {{(32-NUM_SRC){1'b0}}, source_sel_reg};
            `MCR_OFF_STATUS: rdata_next = msg_count_reg;
            default: rdata_next = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata_reg <= 32'h00000000;
        end else if (clk_en) begin
            reg_rdata_reg <= reg_rd ? rdata_next : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------------
    // Message write launcher
    // ------------------------------------------------------------------------
    mcr_msg_launch u_launch (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .fire(fire),
        .addr_in(launch_addr),
        .data_in(data_word),
        .wr_valid_reg(msg_wr_valid),
        .wr_addr_reg(msg_wr_addr),
        .wr_data_reg(msg_wr_data)
    ); // see [R3] see [R20]

endmodule // mcr_cap_regs

/* dv/mcr_cap_regs_assertions.sv */
// Port checker for the capability register block.
`timescale 1ns/1ps
module mcr_cap_regs_assertions #(
    parameter NUM_SRC = 5
) (
    input wire sys_clk,
    input wire resetn,
    input wire clk_en,
    input wire [7:0] reg_addr,
    input wire reg_rd,
    input wire [31:0] reg_rdata_reg,
    input wire [NUM_SRC-1:0] int_cond,
    input wire legacy_int_reg,
    input wire msg_wr_valid,
    input wire [31:0] msg_wr_addr,
    input wire [31:0] msg_wr_data
);
// ----------------------------------------------------------------------------
// Properties
// ----------------------------------------------------------------------------
default clocking @(posedge sys_clk); endclocking
default disable iff (!resetn);
sequence s_rd(a); reg_rd && clk_en && reg_addr == a; endsequence
property p_capability_identifier; s_rd(8'h58) |=> reg_rdata_reg == 32'h05; endproperty
a_capability_identifier: assert property (p_capability_identifier) else $error("capability_identifier wrong");
property p_next; s_rd(8'h59) |=> reg_rdata_reg == 32'h64; endproperty
a_next: assert property (p_next) else $error("next ptr wrong");
property p_pm_data; s_rd(8'h57) |=> reg_rdata_reg == 32'h0; endproperty
a_pm_data: assert property (p_pm_data) else $error("pm data not zero");
property p_bridge; s_rd(8'h56) |=> reg_rdata_reg[7:6] == 2'b00; endproperty
a_bridge: assert property (p_bridge) else $error("bridge bits set");
property p_ctl; s_rd(8'h5a) |=> reg_rdata_reg[3:1] == 3'h1 && !reg_rdata_reg[7]; endproperty
a_ctl: assert property (p_ctl) else $error("control fixed fields wrong");
property p_rd_once; reg_rdata_reg != 32'h0 |-> $past(reg_rd); endproperty
a_rd_once: assert property (p_rd_once) else $error("read data outside slot");
property p_addr; msg_wr_valid |-> msg_wr_addr[1:0] == 2'b00; endproperty
a_addr: assert property (p_addr) else $error("message address low bits");
property p_data; msg_wr_valid |-> msg_wr_data[31:16] == 16'h0; endproperty
a_data: assert property (p_data) else $error("message data high half");
property p_quiet;
    int_cond == 0 && $past(int_cond) == 0 |=> !msg_wr_valid && !legacy_int_reg;
endproperty
a_quiet: assert property (p_quiet) else $error("interrupt with no source");
c_msg: cover property (msg_wr_valid);
c_legacy: cover property (legacy_int_reg);
c_ctl: cover property (s_rd(8'h5a));
endmodule // mcr_cap_regs_assertions

/* dv/mcr_host_model.sv */
// Host that takes upstream interrupt memory writes.
`timescale 1ns/1ps
module mcr_host_model (
    input wire sys_clk,
    input wire resetn,
    input wire msg_wr_valid,
    input wire [31:0] msg_wr_addr,
    input wire [31:0] msg_wr_data
);
logic [31:0] addr_q[$];
logic [31:0] data_q[$];
// ----------------------------------------------------------------------------
// Capture
// ----------------------------------------------------------------------------
always @(posedge sys_clk) begin
    if (resetn && msg_wr_valid) begin
        addr_q.push_back(msg_wr_addr);
        data_q.push_back(msg_wr_data);
    end
end
endmodule // mcr_host_model

/* dv/tb.sv */
// Self-checking bench for the capability register block.
`timescale 1ns/1ps
module tb;
reg sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, doe = 0, ce = 1;
reg [7:0] reg_addr = 8'h0, dov = 8'h0;
reg [31:0] reg_wdata = 32'h0, a = 32'h0, d = 32'h0;
reg [4:0] int_cond = 5'h0;
wire [31:0] rdata, maddr, mdata;
wire mval, leg;
integer err_count = 0, n_compared = 0, seed = 13701, i;
always #10 sys_clk = ~sys_clk;
mcr_cap_regs #(.NUM_SRC(5)) u_mcr_cap_regs (.sys_clk(sys_clk), .resetn(resetn), .clk_en(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_reg(rdata), .int_cond(int_cond), .dest_override(dov), .dest_override_en(doe),
    .legacy_int_reg(leg), .msg_wr_valid(mval), .msg_wr_addr(maddr), .msg_wr_data(mdata));
mcr_host_model u_mcr_host_model (.sys_clk(sys_clk), .resetn(resetn), .msg_wr_valid(mval),
    .msg_wr_addr(maddr), .msg_wr_data(mdata));
task chk(input string nm, input [31:0] e, input [31:0] g);
    n_compared++;
    if (g !== e) begin
        err_count++;
        $display("ERROR %s expected %h seen %h", nm, e, g);
    end
endtask
task tally_and_finish;
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask
task wr(input [7:0] ad, input [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
endtask
task rd(input [7:0] ad, input [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= ad;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata_reg", e, rdata);
endtask
task rd_fixed;
    rd(8'h56, 32'h0);
    rd(8'h57, 32'h0);
    rd(8'h58, 32'h05);
    rd(8'h59, 32'h64);
endtask
// Raises one source and checks the legacy level and the messages that follow.
task fire(input integer s, input integer n, input integer lg);
    integer k0;
    k0 = u_mcr_host_model.addr_q.size();
    @(posedge sys_clk);
    int_cond[s] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk("legacy_int_reg", lg, {31'h0, leg});
    int_cond <= 5'h0;
    repeat (3) @(posedge sys_clk);
    chk("msg count", n, u_mcr_host_model.addr_q.size() - k0);
    if (n > 0) begin
        chk("msg_wr_addr", {a[31:20], (a[3] && doe) ? dov : a[19:12], a[11:0]},
            u_mcr_host_model.addr_q[$]);
        chk("msg_wr_data", {16'h0, d[15:0] | 16'h4000},
            u_mcr_host_model.data_q[$]);
    end
endtask
// ----------------------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------------------
initial begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    rd_fixed;
    rd(8'h5a, 32'h0002);
    rd(8'h5c, 32'hfee00000);
    rd(8'h60, 32'h4000);
    for (i = 0; i < 4; i++) wr(8'h56 + i[7:0], 32'hffffffff);
    rd_fixed;
    rd(8'h40, 32'h0);
    wr(8'h70, 32'h1f);
    @(posedge sys_clk);
    ce <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= 8'h70;
    reg_wdata <= 32'h0;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    ce <= 1'b1;
    rd(8'h70, 32'h1f);
    wr(8'h5a, 32'h11);
    rd(8'h5a, 32'h13);
    for (i = 0; i < 5; i++) begin
        a = $random(seed);
        d = $random(seed);
        dov <= a[7:0];
        doe <= i[0];
        a[31:20] = 12'hfee;
        a[1:0] = 2'b00;
        d[15] = 1'b0;
        d[13:12] = 2'b00;
        wr(8'h5c, a);
        wr(8'h60, {16'h0, d[15:0]});
        rd(8'h5c, a);
        rd(8'h60, {16'h0, d[15:0]} | 32'h4000);
        fire(i, 1, 0);
    end
    d = 32'h8000;
    wr(8'h60, d);
    rd(8'h60, 32'h8000);
    fire(0, 2, 0);
    rd(8'h74, 32'h7);
    wr(8'h70, 32'h0);
    fire(1, 0, 0);
    wr(8'h5a, 32'h0);
    wr(8'h70, 32'h1f);
    fire(2, 0, 1);
    wr(8'h70, 32'h0);
    fire(3, 0, 0);
    tally_and_finish;
end
initial begin
    #1000000;
    err_count++;
    tally_and_finish;
end
endmodule // tb
bind mcr_cap_regs mcr_cap_regs_assertions #(.NUM_SRC(NUM_SRC)) u_mcr_chk (.sys_clk(sys_clk),
    .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata_reg(reg_rdata_reg), .int_cond(int_cond), .legacy_int_reg(legacy_int_reg),
    .msg_wr_valid(msg_wr_valid), .msg_wr_addr(msg_wr_addr), .msg_wr_data(msg_wr_data));
